// ### rtl/vic_controller.v
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "vic_defs.vh"
module vic_controller #(
    parameter NUM_SRC = 10,
    parameter NUM_PIN = 7
) (
    // clock and reset
    input wire ref_clk_in,
    input wire arst_n_in,
    // avalon-mm slave
    input wire [9:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // processor core
    input wire cpu_instr_last_in,
    input wire cpu_return_from_irq_instr_in,
    output reg call_req_out,
    output reg [15:0] call_vector_out,
    output reg [3:0] in_service_out,
    // external pins: 0 ext zero, 1 ext one, 2 ext two, 3..6 ext four channels
    input wire [6:0] ext_pin_in,
    // peripheral flags
    input wire tk_flag_in,
    input wire uart_receive_flag_in,
    input wire uart_send_flag_in,
    input wire timer_two_overflow_flag_in,
    input wire timer_two_external_flag_in,
    input wire timer_four_flag_in,
    input wire twowire_flag_in,
    input wire timer_three_overflow_in
);
    // source indices in polling order
    localparam S_X0 = 0;
    localparam S_TK = 1;
    localparam S_X1 = 2;
    localparam S_UART = 3;
    localparam S_T2 = 4;
    localparam S_T4 = 5;
    localparam S_X2 = 6;
    localparam S_X4 = 7;
    localparam S_TWI = 8;
    localparam S_T3 = 9;

    reg [7:0] primary_en_q;
    reg [7:0] secondary_source_enable_q;
    reg [7:0] ext_int_trigger_control_q;
    reg [7:0] ext_int_mode_flags_q;
    reg [7:0] int4_channel_flags_q;
    reg [7:0] int4_channel_enable_q;
    reg [7:0] priority_high_bank0_q;
    reg [7:0] priority_high_bank1_q;
    reg [7:0] priority_low_bank0_q;
    reg [7:0] priority_low_bank1_q;
    reg [7:0] sample_cnt0_q;
    reg [7:0] sample_cnt1_q;
    reg timer_three_overflow_flag_q;
    reg [3:0] active_q;

    wire [7:0] idx;
    wire wr_go;
    wire [7:0] wd;
    wire [13:0] sample_sel;
    wire [6:0] pin_level;
    wire [6:0] pin_rise;
    wire [6:0] pin_fall;
    wire [NUM_SRC-1:0] src_flag;
    wire [NUM_SRC-1:0] src_en;
    wire [NUM_SRC-1:0] src_req;
    wire [2*NUM_SRC-1:0] src_prio;
    wire [1:0] ext_two_trigger_field;
    wire [1:0] ext_four_trigger_field;
    wire [3:0] ext_four_evt;
    wire global_enable;

    reg [31:0] rdata_d;
    reg win_found;
    reg [3:0] win_sel;
    reg [1:0] win_lvl;
    reg cur_any;
    reg [1:0] cur_lvl;
    reg take_call;
    reg [15:0] vec_d;
    integer i, j;

    assign idx = avs_address_in[9:2];
    assign wd = avs_writedata_in[7:0];
    assign wr_go = avs_write_in & ~avs_waitrequest_out;
    assign sample_sel = {sample_cnt1_q, sample_cnt0_q[5:0]};
    assign ext_two_trigger_field = ext_int_mode_flags_q[`VIC_MF_X2_MODE+1:`VIC_MF_X2_MODE];
    assign ext_four_trigger_field = ext_int_mode_flags_q[`VIC_MF_X4_MODE+1:`VIC_MF_X4_MODE];
    assign global_enable = primary_en_q[`VIC_PEN_GLOBAL];

    genvar g;
    generate
        for (g = 0; g < NUM_PIN; g = g + 1) begin : g_pin
            vic_ext_sampler u_sampler (
                .ref_clk_in(ref_clk_in),
                .arst_n_in(arst_n_in),
                .pin_in(ext_pin_in[g]),
                .count_sel_in(sample_sel[2*g+1:2*g]),
                .level_out(pin_level[g]),
                .rise_out(pin_rise[g]),
                .fall_out(pin_fall[g])
            );
        end
    endgenerate

    // mode decode, shared by ext two and all ext four inputs
    function trig_event;
        input [1:0] mode;
        input lvl;
        input rise;
        input fall;
        begin
            case (mode)
                `VIC_TRIG_LOW: trig_event = ~lvl;
                `VIC_TRIG_FALL: trig_event = fall;
                `VIC_TRIG_RISE: trig_event = rise;
                default: trig_event = rise | fall;
            endcase
        end
    endfunction

    // set wins over both software and vectoring clears
    function flag_next;
        input cur;
        input wr;
        input wbit;
        input hw_clr;
        input set;
        begin
            flag_next = set | ((wr ? wbit : cur) & ~hw_clr);
        end
    endfunction

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_x4
            assign ext_four_evt[g] = int4_channel_enable_q[g] &
                trig_event(ext_four_trigger_field, pin_level[3+g], pin_rise[3+g], pin_fall[3+g]);
        end
    endgenerate

    assign src_flag[S_X0] = ext_int_trigger_control_q[`VIC_TC_X0_FLAG];
    assign src_flag[S_TK] = tk_flag_in;
    assign src_flag[S_X1] = ext_int_trigger_control_q[`VIC_TC_X1_FLAG];
    assign src_flag[S_UART] = uart_receive_flag_in | uart_send_flag_in;
    assign src_flag[S_T2] = timer_two_overflow_flag_in | timer_two_external_flag_in;
    assign src_flag[S_T4] = timer_four_flag_in;
    assign src_flag[S_X2] = ext_int_mode_flags_q[`VIC_MF_X2_FLAG];
    assign src_flag[S_X4] = |int4_channel_flags_q[3:0];
    assign src_flag[S_TWI] = twowire_flag_in;
    assign src_flag[S_T3] = timer_three_overflow_flag_q;

    assign src_en[S_X0] = primary_en_q[`VIC_PEN_X0];
    assign src_en[S_TK] = primary_en_q[`VIC_PEN_TK];
    assign src_en[S_X1] = primary_en_q[`VIC_PEN_X1];
    assign src_en[S_UART] = primary_en_q[`VIC_PEN_UART];
    assign src_en[S_T2] = primary_en_q[`VIC_PEN_T2];
    assign src_en[S_T4] = secondary_source_enable_q[`VIC_SEN_T4];
    assign src_en[S_X2] = secondary_source_enable_q[`VIC_SEN_X2];
    assign src_en[S_X4] = secondary_source_enable_q[`VIC_SEN_X4];
    assign src_en[S_TWI] = secondary_source_enable_q[`VIC_SEN_TWI];
    assign src_en[S_T3] = secondary_source_enable_q[`VIC_SEN_T3];

    assign src_req = src_flag & src_en & {NUM_SRC{global_enable}};

    // priority bit map, high bit over low bit
    assign src_prio[2*S_X0+1:2*S_X0] = {priority_high_bank0_q[`VIC_PB0_X0],
                                        priority_low_bank0_q[`VIC_PB0_X0]};
    assign src_prio[2*S_TK+1:2*S_TK] = {priority_high_bank0_q[`VIC_PB0_TK],
                                        priority_low_bank0_q[`VIC_PB0_TK]};
    assign src_prio[2*S_X1+1:2*S_X1] = {priority_high_bank0_q[`VIC_PB0_X1],
                                        priority_low_bank0_q[`VIC_PB0_X1]};
    assign src_prio[2*S_UART+1:2*S_UART] = {priority_high_bank0_q[`VIC_PB0_UART],
                                            priority_low_bank0_q[`VIC_PB0_UART]};
    assign src_prio[2*S_T2+1:2*S_T2] = {priority_high_bank0_q[`VIC_PB0_T2],
                                        priority_low_bank0_q[`VIC_PB0_T2]};
    assign src_prio[2*S_T4+1:2*S_T4] = {priority_high_bank0_q[`VIC_PB0_T4],
                                        priority_low_bank0_q[`VIC_PB0_T4]};
    assign src_prio[2*S_X2+1:2*S_X2] = {priority_high_bank1_q[`VIC_PB1_X2],
                                        priority_low_bank1_q[`VIC_PB1_X2]};
    assign src_prio[2*S_X4+1:2*S_X4] = {priority_high_bank1_q[`VIC_PB1_X4],
                                        priority_low_bank1_q[`VIC_PB1_X4]};
    assign src_prio[2*S_TWI+1:2*S_TWI] = {priority_high_bank0_q[`VIC_PB0_TWI],
                                          priority_low_bank0_q[`VIC_PB0_TWI]};
    assign src_prio[2*S_T3+1:2*S_T3] = {priority_high_bank1_q[`VIC_PB1_T3],
                                        priority_low_bank1_q[`VIC_PB1_T3]};

    always @* begin
        win_found = 1'b0;
        win_sel = 4'h0;
        win_lvl = 2'b00;
        // level first, then polling order (walk backward so earlier wins ties)
        for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (src_req[i] && (!win_found || src_prio[2*i+:2] >= win_lvl)) begin
                win_found = 1'b1;
                win_sel = i[3:0];
                win_lvl = src_prio[2*i+:2];
            end
        end
        cur_any = |active_q;
        cur_lvl = active_q[3] ? 2'd3 : active_q[2] ? 2'd2 : active_q[1] ? 2'd1 : 2'd0;
        // blocking terms, no call at the end of a return instruction
        // strictly higher only, so level three is never preempted
        take_call = win_found && cpu_instr_last_in && !cpu_return_from_irq_instr_in &&
            (!cur_any || win_lvl > cur_lvl);
    end

    // vector lookup; the core pushes only the counter, not the status word
    always @* begin
        case (win_sel)
            S_X0: vec_d = `VIC_VEC_X0;
            S_TK: vec_d = `VIC_VEC_TK;
            S_X1: vec_d = `VIC_VEC_X1;
            S_UART: vec_d = `VIC_VEC_UART;
            S_T2: vec_d = `VIC_VEC_T2;
            S_T4: vec_d = `VIC_VEC_T4;
            S_X2: vec_d = `VIC_VEC_X2;
            S_X4: vec_d = `VIC_VEC_X4;
            S_TWI: vec_d = `VIC_VEC_TWI;
            S_T3: vec_d = `VIC_VEC_T3;
            default: vec_d = 16'h0000;
        endcase
    end

    // poll on every rising edge, call issued at an instruction boundary
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            call_req_out <= 1'b0;
            call_vector_out <= 16'h0000;
            active_q <= 4'h0;
        end else begin
            call_req_out <= take_call;
            if (take_call) begin
                call_vector_out <= vec_d;
                active_q[win_lvl] <= 1'b1;
            // return ends the highest in-service level
            end else if (cpu_return_from_irq_instr_in && cpu_instr_last_in) begin
                if (active_q[3])
                    active_q[3] <= 1'b0;
                else if (active_q[2])
                    active_q[2] <= 1'b0;
                else if (active_q[1])
                    active_q[1] <= 1'b0;
                else
                    active_q[0] <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            in_service_out <= 4'h0;
        end else begin
            in_service_out <= active_q;
        end
    end

    // flag registers
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_int_trigger_control_q <= `VIC_RST_REG;
            ext_int_mode_flags_q <= `VIC_RST_REG;
            int4_channel_flags_q <= `VIC_RST_REG;
            timer_three_overflow_flag_q <= 1'b0;
        end else begin
            // mode bits: zero low level, one falling edge
            if (wr_go && idx == `VIC_IDX_TRIG_CTRL) begin
                ext_int_trigger_control_q[`VIC_TC_X0_MODE] <= wd[`VIC_TC_X0_MODE];
                ext_int_trigger_control_q[`VIC_TC_X1_MODE] <= wd[`VIC_TC_X1_MODE];
            end
            // level tracks pin, edge cleared on vectoring
            if (!ext_int_trigger_control_q[`VIC_TC_X0_MODE])
                ext_int_trigger_control_q[`VIC_TC_X0_FLAG] <= ~pin_level[0];
            else
                ext_int_trigger_control_q[`VIC_TC_X0_FLAG] <= flag_next(
                    ext_int_trigger_control_q[`VIC_TC_X0_FLAG],
                    wr_go && idx == `VIC_IDX_TRIG_CTRL, wd[`VIC_TC_X0_FLAG],
                    take_call && win_sel == S_X0, pin_fall[0]);
            if (!ext_int_trigger_control_q[`VIC_TC_X1_MODE])
                ext_int_trigger_control_q[`VIC_TC_X1_FLAG] <= ~pin_level[1];
            else
                ext_int_trigger_control_q[`VIC_TC_X1_FLAG] <= flag_next(
                    ext_int_trigger_control_q[`VIC_TC_X1_FLAG],
                    wr_go && idx == `VIC_IDX_TRIG_CTRL, wd[`VIC_TC_X1_FLAG],
                    take_call && win_sel == S_X1, pin_fall[1]);
            if (wr_go && idx == `VIC_IDX_MODE_FLAGS) begin
                ext_int_mode_flags_q[7:6] <= wd[7:6];
                ext_int_mode_flags_q[3:2] <= wd[3:2];
            end
            // ext two pending flag, same clearing scheme
            if (ext_two_trigger_field == `VIC_TRIG_LOW)
                ext_int_mode_flags_q[`VIC_MF_X2_FLAG] <= ~pin_level[2];
            else
                ext_int_mode_flags_q[`VIC_MF_X2_FLAG] <= flag_next(
                    ext_int_mode_flags_q[`VIC_MF_X2_FLAG],
                    wr_go && idx == `VIC_IDX_MODE_FLAGS, wd[`VIC_MF_X2_FLAG],
                    take_call && win_sel == S_X2,
                    trig_event(ext_two_trigger_field, pin_level[2], pin_rise[2], pin_fall[2]));
            // sticky channel flags, cleared only by software write
            for (j = 0; j < 4; j = j + 1)
                int4_channel_flags_q[j] <= flag_next(int4_channel_flags_q[j],
                    wr_go && idx == `VIC_IDX_CHAN_FLAGS, wd[j], 1'b0, ext_four_evt[j]);
            // hardware clears timer three flag on the call
            timer_three_overflow_flag_q <= flag_next(timer_three_overflow_flag_q,
                wr_go && idx == `VIC_IDX_STATUS, wd[4],
                take_call && win_sel == S_T3, timer_three_overflow_in);
        end
    end

    // plain read/write configuration registers
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            primary_en_q <= `VIC_RST_REG;
            secondary_source_enable_q <= `VIC_RST_REG;
            int4_channel_enable_q <= `VIC_RST_REG;
            priority_high_bank0_q <= `VIC_RST_REG;
            priority_high_bank1_q <= `VIC_RST_REG;
            priority_low_bank0_q <= `VIC_RST_REG;
            priority_low_bank1_q <= `VIC_RST_REG;
            sample_cnt0_q <= `VIC_RST_REG;
            sample_cnt1_q <= `VIC_RST_REG;
        end else if (wr_go) begin
            case (idx)
                `VIC_IDX_PRIMARY_EN: primary_en_q <= wd & 8'hb7;
                `VIC_IDX_SECONDARY_EN: secondary_source_enable_q <= wd & 8'h1f;
                `VIC_IDX_CHAN_EN: int4_channel_enable_q <= wd;
                `VIC_IDX_PRIO_HIGH0: priority_high_bank0_q <= wd & 8'h7f;
                `VIC_IDX_PRIO_HIGH1: priority_high_bank1_q <= wd & 8'h16;
                `VIC_IDX_PRIO_LOW0: priority_low_bank0_q <= wd & 8'h7f;
                `VIC_IDX_PRIO_LOW1: priority_low_bank1_q <= wd & 8'h16;
                `VIC_IDX_SAMPLE_CNT0: sample_cnt0_q <= wd & 8'h3f;
                `VIC_IDX_SAMPLE_CNT1: sample_cnt1_q <= wd;
                default: ;
            endcase
        end
    end

    // read mux, unmapped reads as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (idx)
            `VIC_IDX_TRIG_CTRL: rdata_d[7:0] = ext_int_trigger_control_q & 8'h0f;
            `VIC_IDX_PRIMARY_EN: rdata_d[7:0] = primary_en_q;
            `VIC_IDX_SECONDARY_EN: rdata_d[7:0] = secondary_source_enable_q;
            `VIC_IDX_SAMPLE_CNT0: rdata_d[7:0] = sample_cnt0_q;
            `VIC_IDX_SAMPLE_CNT1: rdata_d[7:0] = sample_cnt1_q;
            `VIC_IDX_PRIO_HIGH0: rdata_d[7:0] = priority_high_bank0_q;
            `VIC_IDX_PRIO_HIGH1: rdata_d[7:0] = priority_high_bank1_q;
            `VIC_IDX_PRIO_LOW0: rdata_d[7:0] = priority_low_bank0_q;
            `VIC_IDX_PRIO_LOW1: rdata_d[7:0] = priority_low_bank1_q;
            `VIC_IDX_CHAN_EN: rdata_d[7:0] = int4_channel_enable_q;
            `VIC_IDX_CHAN_FLAGS: rdata_d[7:0] = int4_channel_flags_q & 8'h0f;
            `VIC_IDX_MODE_FLAGS: rdata_d[7:0] = ext_int_mode_flags_q & 8'hcd;
            `VIC_IDX_STATUS: rdata_d[7:0] = {3'b000, timer_three_overflow_flag_q, active_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // one wait state: every access ends on the second edge
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_waitrequest_out && (avs_read_in || avs_write_in)) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= rdata_d;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end
endmodule // vic_controller

// ### rtl/vic_defs.vh
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// register indices, byte address is four times the index
`define VIC_IDX_TRIG_CTRL 8'h88
`define VIC_IDX_PRIMARY_EN 8'ha8
`define VIC_IDX_SECONDARY_EN 8'ha9
`define VIC_IDX_SAMPLE_CNT0 8'had
`define VIC_IDX_SAMPLE_CNT1 8'hae
`define VIC_IDX_PRIO_HIGH0 8'hb4
`define VIC_IDX_PRIO_HIGH1 8'hb5
`define VIC_IDX_PRIO_LOW0 8'hb8
`define VIC_IDX_PRIO_LOW1 8'hb9
`define VIC_IDX_CHAN_EN 8'hba
`define VIC_IDX_CHAN_FLAGS 8'hd8
`define VIC_IDX_MODE_FLAGS 8'he8
`define VIC_IDX_STATUS 8'hf0

`define VIC_RST_REG 8'h00

// primary enable fields
`define VIC_PEN_GLOBAL 7
`define VIC_PEN_T2 5
`define VIC_PEN_UART 4
`define VIC_PEN_X1 2
`define VIC_PEN_TK 1
`define VIC_PEN_X0 0
// secondary enable fields
`define VIC_SEN_T3 4
`define VIC_SEN_TWI 3
`define VIC_SEN_X4 2
`define VIC_SEN_X2 1
`define VIC_SEN_T4 0
// trigger control fields
`define VIC_TC_X1_FLAG 3
`define VIC_TC_X1_MODE 2
`define VIC_TC_X0_FLAG 1
`define VIC_TC_X0_MODE 0
// mode/flag register fields
`define VIC_MF_X4_MODE 6
`define VIC_MF_X2_MODE 2
`define VIC_MF_X2_FLAG 0
// priority bank bit positions
`define VIC_PB0_T4 6
`define VIC_PB0_T2 5
`define VIC_PB0_UART 4
`define VIC_PB0_TK 3
`define VIC_PB0_X1 2
`define VIC_PB0_TWI 1
`define VIC_PB0_X0 0
`define VIC_PB1_T3 4
`define VIC_PB1_X4 2
`define VIC_PB1_X2 1

// trigger modes
`define VIC_TRIG_LOW 2'b00
`define VIC_TRIG_FALL 2'b01
`define VIC_TRIG_RISE 2'b10
`define VIC_TRIG_BOTH 2'b11

// consecutive sample counts
`define VIC_SAMPLES_SEL0 5'h01
`define VIC_SAMPLES_SEL1 5'h04
`define VIC_SAMPLES_SEL2 5'h08
`define VIC_SAMPLES_SEL3 5'h10

// vectors in polling order
`define VIC_VEC_X0 16'h0003
`define VIC_VEC_TK 16'h000b
`define VIC_VEC_X1 16'h0013
`define VIC_VEC_UART 16'h0023
`define VIC_VEC_T2 16'h002b
`define VIC_VEC_T4 16'h003b
`define VIC_VEC_X2 16'h0043
`define VIC_VEC_X4 16'h004b
`define VIC_VEC_TWI 16'h0053
`define VIC_VEC_T3 16'h005b

`endif

// ### rtl/vic_ext_sampler.v
`timescale 1ns/100ps
`include "vic_defs.vh"
module vic_ext_sampler (
    // clock and reset
    input wire ref_clk_in,
    input wire arst_n_in,
    // pin and configuration
    input wire pin_in,
    input wire [1:0] count_sel_in,
    // filtered level and edges
    output reg level_out,
    output reg rise_out,
    output reg fall_out
);
    reg [4:0] cnt_q;
    reg [4:0] limit;
    wire [4:0] cnt_inc;

    always @* begin
        case (count_sel_in)
            2'b00: limit = `VIC_SAMPLES_SEL0;
            2'b01: limit = `VIC_SAMPLES_SEL1;
            2'b10: limit = `VIC_SAMPLES_SEL2;
            default: limit = `VIC_SAMPLES_SEL3;
        endcase
    end

    assign cnt_inc = cnt_q + 5'h01;

    // idle high, so a pin held low from reset reads as a falling edge
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_out <= 1'b1;
            cnt_q <= 5'h00;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            if (pin_in == level_out) begin
                cnt_q <= 5'h00;
            end else if (cnt_inc >= limit) begin
                cnt_q <= 5'h00;
                level_out <= pin_in;
                rise_out <= pin_in;
                fall_out <= ~pin_in;
            end else begin
                cnt_q <= cnt_inc;
            end
        end
    end
endmodule // vic_ext_sampler

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    reg clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, return_from_irq_instr_req = 1'b0;
    reg tk = 1'b0, urx = 1'b0, usend = 1'b0, t3 = 1'b0;
    reg [9:0] addr = 10'h000;
    reg [31:0] wdata = 32'h0, got;
    reg [6:0] pins = 7'h7f;
    reg [23:0] rows [0:16];
    wire [31:0] rdata;
    wire waitr, last, return_from_irq_instr, call;
    wire [15:0] vec;
    wire [3:0] insvc;
    integer n_mismatch = 0, tests_run = 0, n_calls = 0, n0, i;
    always #5 clk = ~clk;
    always @(posedge clk) if (call === 1'b1) n_calls <= n_calls + 1;
    vic_controller i_vic_controller (.ref_clk_in(clk), .arst_n_in(arst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitr), .cpu_instr_last_in(last), .cpu_return_from_irq_instr_in(return_from_irq_instr),
        .call_req_out(call), .call_vector_out(vec), .in_service_out(insvc), .ext_pin_in(pins),
        .tk_flag_in(tk), .uart_receive_flag_in(urx), .uart_send_flag_in(usend),
        .timer_two_overflow_flag_in(1'b0), .timer_two_external_flag_in(1'b0),
        .timer_four_flag_in(1'b0), .twowire_flag_in(1'b0), .timer_three_overflow_in(t3));
    vic_cpu_model #(.INSTR_LEN(4'h3)) i_vic_cpu_model (.ref_clk_in(clk), .arst_n_in(arst_n),
        .return_from_irq_instr_req_in(return_from_irq_instr_req), .instr_last_out(last), .return_from_irq_instr_out(return_from_irq_instr));
    task tally_and_finish;
        begin
            $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
            if (n_mismatch == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task bus(input w, input [7:0] idx, input [7:0] d);
        integer k;
        begin
            @(posedge clk);
            addr <= {idx, 2'b00};
            rd <= !w;
            wr <= w;
            wdata <= {24'h0, d};
            k = 0;
            do begin @(posedge clk); k = k + 1; end while (waitr !== 1'b0 && k < 50);
            got = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            if (waitr !== 1'b0) begin n_mismatch = n_mismatch + 1; tally_and_finish; end
        end
    endtask
    task wait_call(input [15:0] e);
        integer k;
        begin
            k = 0;
            do begin @(posedge clk); k = k + 1; end while (call !== 1'b1 && k < 200);
            chk({15'h0, call, vec}, {15'h0, 1'b1, e});
            if (call !== 1'b1) tally_and_finish;
            @(posedge clk);
        end
    endtask
    task do_return_from_irq_instr;
        integer k;
        begin
            @(posedge clk);
            return_from_irq_instr_req <= 1'b1;
            k = 0;
            do begin @(posedge clk); k = k + 1; end while (last !== 1'b1 && k < 20);
            return_from_irq_instr_req <= 1'b0;
            if (last !== 1'b1) begin n_mismatch = n_mismatch + 1; tally_and_finish; end
        end
    endtask
    task quiet;
        begin
            n0 = n_calls;
            repeat (12) @(posedge clk);
            chk(n_calls - n0, 32'h0);
        end
    endtask
    initial begin
        rows = '{24'h880505, 24'ha8ffb7, 24'ha9ff1f, 24'hb4ff7f, 24'hb5ff16, 24'hb8ff7f,
            24'hb9ff16, 24'hbaffff, 24'hd8f000, 24'he8cecc, 24'h20ff00, 24'hb40000,
            24'hb50000, 24'hb90000, 24'ha90000, 24'hb81000, 24'ha89200};
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 11; i = i + 1) begin
            bus(1'b0, rows[i][23:16], 8'h00);
            chk(got, 32'h0);
            bus(1'b1, rows[i][23:16], rows[i][15:8]);
            bus(1'b0, rows[i][23:16], 8'h00);
            chk(got, {24'h0, rows[i][7:0]});
        end
        for (i = 11; i < 17; i = i + 1) bus(1'b1, rows[i][23:16], rows[i][15:8]);
        tk <= 1'b1;
        urx <= 1'b1;
        usend <= 1'b1;
        wait_call(16'h0023);
        chk({28'h0, insvc}, 32'h2);
        quiet;
        urx <= 1'b0;
        usend <= 1'b0;
        do_return_from_irq_instr;
        wait_call(16'h000b);
        chk({28'h0, insvc}, 32'h1);
        bus(1'b1, 8'ha8, 8'h12);
        do_return_from_irq_instr;
        quiet;
        bus(1'b1, 8'ha8, 8'h81);
        pins <= 7'h7e;
        wait_call(16'h0003);
        bus(1'b0, 8'h88, 8'h00);
        chk(got, 32'h05);
        do_return_from_irq_instr;
        bus(1'b1, 8'ha9, 8'h10);
        t3 <= 1'b1;
        @(posedge clk);
        t3 <= 1'b0;
        wait_call(16'h005b);
        bus(1'b0, 8'hf0, 8'h00);
        chk(got, 32'h01);
        tally_and_finish;
    end
endmodule // tb_top

// ### verif/vic_cpu_model.sv
`timescale 1ns/100ps
module vic_cpu_model #(parameter [3:0] INSTR_LEN = 4'h2) (
    // clock and reset
    input wire ref_clk_in,
    input wire arst_n_in,
    // bench control and core status
    input wire return_from_irq_instr_req_in,
    output wire instr_last_out,
    output wire return_from_irq_instr_out
);
    reg [3:0] cyc_q;
    // multi-cycle instructions exercise the mid-instruction block
    assign instr_last_out = (cyc_q == INSTR_LEN - 4'h1);
    assign return_from_irq_instr_out = return_from_irq_instr_req_in;
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) cyc_q <= 4'h0;
        else cyc_q <= instr_last_out ? 4'h0 : cyc_q + 4'h1;
    end
endmodule // vic_cpu_model

// ### verif/vic_ctrl_asserts.sv
`timescale 1ns/100ps
module vic_ctrl_asserts (
    // clock and reset
    input wire ref_clk_in,
    input wire arst_n_in,
    // register bus
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // processor core
    input wire cpu_instr_last_in,
    input wire cpu_return_from_irq_instr_in,
    input wire call_req_out,
    input wire [15:0] call_vector_out,
    input wire [3:0] in_service_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_pulse; call_req_out |=> !call_req_out; endproperty
    a_pulse: assert property (p_pulse) else $error("call pulse too long");
    property p_edge; $rose(call_req_out) |-> $past(cpu_instr_last_in) && !$past(cpu_return_from_irq_instr_in);
    endproperty
    a_edge: assert property (p_edge) else $error("call off a boundary");
    property p_return_from_irq_instr; cpu_instr_last_in && cpu_return_from_irq_instr_in |=> !call_req_out; endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("call after return");
    property p_top; call_req_out |-> !in_service_out[3]; endproperty
    a_top: assert property (p_top) else $error("top level preempted");
    property p_mark; call_req_out |=> in_service_out != 4'h0; endproperty
    a_mark: assert property (p_mark) else $error("level not marked");
    property p_vec; $changed(call_vector_out) |-> call_req_out; endproperty
    a_vec: assert property (p_vec) else $error("vector moved without call");
    property p_ack; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_ack: assert property (p_ack) else $error("bus answer too long");
    property p_up; !avs_waitrequest_out && avs_read_in |-> avs_readdata_out[31:8] == 24'h0;
    endproperty
    a_up: assert property (p_up) else $error("upper read bits set");
endmodule // vic_ctrl_asserts
bind vic_controller vic_ctrl_asserts i_vic_ctrl_asserts (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .cpu_instr_last_in(cpu_instr_last_in), .cpu_return_from_irq_instr_in(cpu_return_from_irq_instr_in),
    .call_req_out(call_req_out), .call_vector_out(call_vector_out),
    .in_service_out(in_service_out));
